// [hw/async_serial_pkg.sv]
// package: register map, field layouts and enums of the async serial port
package async_serial_pkg;
  // word indices; the byte address is four times the index
  localparam logic [5:0] IDX_BAUD   = 6'h0D;
  localparam logic [5:0] IDX_CTRL1  = 6'h0E;
  localparam logic [5:0] IDX_CTRL2  = 6'h0F;
  localparam logic [5:0] IDX_STATUS = 6'h10;
  localparam logic [5:0] IDX_DATA   = 6'h11;
  // positions inside one bit time of sixteen oversample ticks
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_HALF = 4'h8;
  localparam logic [3:0] VER_A    = 4'h3;
  localparam logic [3:0] VER_B    = 4'h5;
  localparam logic [3:0] VER_C    = 4'h7;
  localparam logic [3:0] SMP_A    = 4'h8;
  localparam logic [3:0] SMP_B    = 4'h9;
  localparam logic [3:0] SMP_C    = 4'hA;
  localparam logic [3:0] FRAME_LEN8 = 4'hA;
  localparam logic [3:0] FRAME_LEN9 = 4'hB;
  localparam logic [3:0] DATA_LAST8 = 4'h8;
  localparam logic [3:0] DATA_LAST9 = 4'h9;
  localparam logic [7:0] IDLE_TICKS8 = 8'hA0;
  localparam logic [7:0] IDLE_TICKS9 = 8'hB0;
  typedef struct packed {
    logic rx_bit8;
    logic tx_bit8;
    logic rsvd;
    logic word9;
    logic wake_addr;
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic last_bit_clock_sel;
  } serial_control_one_t;
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_complete_irq_en;
    logic rx_irq_en;
    logic idle_irq_en;
    logic tx_enable;
    logic rx_enable;
    logic rx_sleep_ctrl;
    logic send_break_ctrl;
  } serial_control_two_t;
  typedef struct packed {
    logic tx_buffer_empty;
    logic tx_complete;
    logic rx_buffer_full;
    logic idle;
    logic overrun;
    logic noise_flag;
    logic frame_error_flag;
    logic rsvd;
  } serial_status_t;
  typedef struct packed {
    logic [1:0] presc;
    logic [2:0] tx_sel;
    logic [2:0] rx_sel;
  } baud_t;
  localparam serial_status_t STATUS_RST = 8'hC0;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_BRK, TX_MARK, TX_DATA} tx_kind_t;
  typedef enum logic [1:0] {RX_WAIT_ONE, RX_IDLE, RX_START, RX_BITS} rx_state_t;
endpackage

// [hw/async_serial_unit.sv]
// async serial port: wishbone registers, baud divider, transmitter, receiver
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
// Functional notes
// R1 - receiver waits for start at 16x tick
// R2 - start needs two of three low samples
// R3 - each bit sampled thrice, majority vote
// R4 - disagreeing samples set the noise flag
// R5 - framing error acts as stop, early restart
// R6 - break frame needs a one before start
// R7 - idle-mode sleep wakes after idle string
// R8 - address-mode sleep wakes on msb one
// R9 - far transmitter places idle strings between messages
// R10 - sync clock only on data bits
// R11 - last-bit, polarity, phase controls shape clock
// R12 - disabled transmitter floats data and clock
// R13 - software fixes clock controls before enabling
// R14 - bit time is sixteen oversample ticks
// R15 - data write loads shifter, sets buffer empty
// R16 - load aligned to bit clock, lsb first
// R17 - transmit complete when nothing left pending
// R18 - disable mid-character finishes that character
// R19 - received byte sets receive full, readable
// R20 - overrun, noise, framing flags on errors
// R21 - idle flag only after a character
// R22 - thirty-two rates, separate tx and rx
// R23 - word length selects eight or nine bits
// R24 - overrun keeps old data, drops new
// R25 - status then data read clears rx flags
// R26 - status then data write clears tx flags
// R27 - start zero, stop one, idle one
module async_serial_unit (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        serial_in_pin_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             tx_data_o,
  output logic             tx_data_oe_n_o,
  output logic             sync_clk_o,
  output logic             sync_clk_oe_n_o,
  output logic             irq_o
);
  typedef struct packed {
    logic                                ack;
    logic [7:0]                          rdat;
    logic                                irq;
    async_serial_pkg::serial_control_one_t c1;
    async_serial_pkg::serial_control_two_t c2;
    async_serial_pkg::baud_t             baud;
    async_serial_pkg::serial_status_t    st;
    logic                                arm;
    logic [7:0]                          tx_hold;
    logic [7:0]                          rx_hold;
    logic [1:0]                          pre_cnt;
    logic [6:0]                          div_cnt;
    logic                                sync0;
    logic                                sync1;
    async_serial_pkg::tx_kind_t          tx_kind;
    logic [3:0]                          tx_sub;
    logic [3:0]                          tx_idx;
    logic [3:0]                          tx_len;
    logic [10:0]                         tx_sh;
    logic                                pre_pend;
    logic                                te_d;
    logic                                brk_last;
    logic                                tx_line;
    logic                                tx_oe_n;
    logic                                sclk;
    logic                                sclk_oe_n;
    async_serial_pkg::rx_state_t         rx_state;
    logic [3:0]                          rx_sub;
    logic [3:0]                          rx_idx;
    logic [2:0]                          rx_smp;
    logic                                rx_noise;
    logic [8:0]                          rx_sh;
    logic [7:0]                          idle_cnt;
    logic                                rx_seen;
  } state_t;

  state_t     s;
  state_t     next_s;
  logic       req;
  logic       hit_w;
  logic [5:0] idx;
  logic       stat_rd;
  logic       dat_rd;
  logic       dat_wr;
  logic       presc_tick;
  logic [6:0] rx_mask;
  logic [6:0] tx_mask;
  logic       rx_tick;
  logic       tx_tick;
  logic       tx_bit;
  logic [3:0] nlen;
  logic [3:0] dlast;
  logic [7:0] idle_ticks;
  logic       tx_load;
  logic       rx_done;
  logic       rx_fill;
  logic [2:0] trio;
  logic       vote;
  logic       dis;
  logic       msb;
  logic       brk;
  logic       wake_hit;
  logic       sclk_act;

  function automatic logic maj(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  assign req        = wb_cyc_i & wb_stb_i & ~s.ack;
  assign hit_w      = req & wb_we_i & wb_sel_i[0];
  assign idx        = wb_adr_i[7:2];
  assign stat_rd    = req & ~wb_we_i & (idx == async_serial_pkg::IDX_STATUS);
  assign dat_rd     = req & ~wb_we_i & (idx == async_serial_pkg::IDX_DATA);
  assign dat_wr     = hit_w & (idx == async_serial_pkg::IDX_DATA);
  // prescaler (1..4) then binary divider (1..128): 32 rates per direction
  assign presc_tick = (s.pre_cnt == 2'h0);
  assign rx_mask    = 7'((8'h01 << s.baud.rx_sel) - 8'h01);
  assign tx_mask    = 7'((8'h01 << s.baud.tx_sel) - 8'h01);
  assign rx_tick    = presc_tick & ((s.div_cnt & rx_mask) == rx_mask); // [R1] [R22]
  assign tx_tick    = presc_tick & ((s.div_cnt & tx_mask) == tx_mask); // [R22]
  assign tx_bit     = tx_tick & (s.tx_sub == async_serial_pkg::SUB_LAST); // [R14]
  assign nlen       = s.c1.word9 ? async_serial_pkg::FRAME_LEN9 : async_serial_pkg::FRAME_LEN8;
  assign dlast      = s.c1.word9 ? async_serial_pkg::DATA_LAST9 : async_serial_pkg::DATA_LAST8;
  assign idle_ticks = s.c1.word9 ? async_serial_pkg::IDLE_TICKS9 : async_serial_pkg::IDLE_TICKS8;

  always_comb begin
    next_s   = s;
    tx_load  = 1'b0;
    rx_done  = 1'b0;
    rx_fill  = 1'b0;
    trio     = 3'h0;
    vote     = 1'b0;
    dis      = 1'b0;
    msb      = 1'b0;
    brk      = 1'b0;
    wake_hit = 1'b0;
    sclk_act = 1'b0;
    next_s.ack   = req;
    next_s.sync0 = serial_in_pin_i;
    next_s.sync1 = s.sync0;
    // register reads; unmapped words read zero
    if (req && !wb_we_i) begin
      case (idx)
        async_serial_pkg::IDX_BAUD:   next_s.rdat = s.baud;
        async_serial_pkg::IDX_CTRL1:  next_s.rdat = s.c1;
        async_serial_pkg::IDX_CTRL2:  next_s.rdat = s.c2;
        async_serial_pkg::IDX_STATUS: next_s.rdat = s.st;
        async_serial_pkg::IDX_DATA:   next_s.rdat = s.rx_hold; // [R19]
        default:                      next_s.rdat = 8'h00;
      endcase
    end
    if (hit_w) begin
      case (idx)
        async_serial_pkg::IDX_BAUD:  next_s.baud = wb_dat_i[7:0];
        async_serial_pkg::IDX_CTRL1: begin
          next_s.c1         = wb_dat_i[7:0];
          next_s.c1.rx_bit8 = s.c1.rx_bit8;
          next_s.c1.rsvd    = 1'b0;
        end
        async_serial_pkg::IDX_CTRL2: next_s.c2 = wb_dat_i[7:0];
        async_serial_pkg::IDX_DATA: begin
          next_s.tx_hold            = wb_dat_i[7:0];
          next_s.st.tx_buffer_empty = 1'b0;
        end
        default: ;
      endcase
    end
    // two-step flag clearing; hardware sets below win
    if (stat_rd) next_s.arm = 1'b1;
    if (dat_rd) begin
      if (s.arm) begin
        next_s.st.rx_buffer_full   = 1'b0; // [R25]
        next_s.st.idle             = 1'b0;
        next_s.st.overrun          = 1'b0;
        next_s.st.noise_flag       = 1'b0;
        next_s.st.frame_error_flag = 1'b0;
      end
      next_s.arm = 1'b0;
    end
    if (dat_wr) begin
      if (s.arm) next_s.st.tx_complete = 1'b0; // [R26]
      next_s.arm = 1'b0;
    end
    // baud generator
    next_s.pre_cnt = presc_tick ? s.baud.presc : s.pre_cnt - 2'h1;
    if (presc_tick) next_s.div_cnt = s.div_cnt + 7'h01;
    // transmitter: new frames only start on a bit boundary
    next_s.te_d = s.c2.tx_enable;
    if (s.c2.tx_enable && !s.te_d) next_s.pre_pend = 1'b1;
    if (tx_tick) next_s.tx_sub = s.tx_sub + 4'h1; // [R14]
    if (tx_bit) begin
      if (s.tx_kind != async_serial_pkg::TX_IDLE && s.tx_idx != s.tx_len - 4'h1) begin
        next_s.tx_idx = s.tx_idx + 4'h1;
        next_s.tx_sh  = {1'b1, s.tx_sh[10:1]}; // [R16]
      end else begin
        next_s.tx_idx = 4'h0;
        next_s.tx_len = nlen; // [R23]
        if (s.c2.tx_enable && s.pre_pend) begin
          next_s.tx_kind  = async_serial_pkg::TX_PRE;
          next_s.tx_sh    = '1;
          next_s.pre_pend = 1'b0;
        end else if (s.c2.tx_enable && s.c2.send_break_ctrl) begin
          next_s.tx_kind  = async_serial_pkg::TX_BRK;
          next_s.tx_sh    = '0;
          next_s.brk_last = 1'b1;
        end else if (s.c2.tx_enable && s.brk_last) begin
          // one mark bit after a break so the far end sees a start edge
          next_s.tx_kind  = async_serial_pkg::TX_MARK;
          next_s.tx_sh    = '1;
          next_s.tx_len   = 4'h1;
          next_s.brk_last = 1'b0;
        end else if (s.c2.tx_enable && !s.st.tx_buffer_empty) begin
          next_s.tx_kind = async_serial_pkg::TX_DATA;
          next_s.tx_sh   = {1'b1, s.c1.word9 ? s.c1.tx_bit8 : 1'b1, s.tx_hold, 1'b0}; // [R27]
          tx_load        = 1'b1; // [R15] [R16]
          if (!dat_wr) next_s.st.tx_buffer_empty = 1'b1; // [R15]
        end else begin
          next_s.tx_kind = async_serial_pkg::TX_IDLE;
          if (s.tx_kind != async_serial_pkg::TX_IDLE) next_s.st.tx_complete = 1'b1; // [R17]
        end
      end
    end
    // a frame in flight keeps the pins even after disable
    next_s.tx_oe_n = !(s.c2.tx_enable || next_s.tx_kind != async_serial_pkg::TX_IDLE); // [R12] [R18]
    next_s.tx_line = (next_s.tx_kind == async_serial_pkg::TX_IDLE) || next_s.tx_sh[0]; // [R27]
    sclk_act = (next_s.tx_kind == async_serial_pkg::TX_DATA) && (next_s.tx_idx != 4'h0)
             && (next_s.tx_idx <= dlast)
             && (next_s.tx_idx != dlast || s.c1.last_bit_clock_sel) // [R11]
             && (s.c1.clock_phase_sel ? next_s.tx_sub < async_serial_pkg::SUB_HALF
                                      : next_s.tx_sub >= async_serial_pkg::SUB_HALF); // [R10]
    next_s.sclk      = s.c1.clock_polarity_sel ^ sclk_act; // [R11]
    next_s.sclk_oe_n = next_s.tx_oe_n; // [R12]
    // receiver
    if (rx_tick) begin
      if (!s.sync1) next_s.idle_cnt = 8'h00;
      else if (s.idle_cnt < idle_ticks) next_s.idle_cnt = s.idle_cnt + 8'h01;
      if (s.sync1 && s.idle_cnt == idle_ticks - 8'h01) begin
        if (s.c2.rx_sleep_ctrl && !s.c1.wake_addr) begin
          next_s.c2.rx_sleep_ctrl = 1'b0; // [R7]
        end else if (!s.c2.rx_sleep_ctrl && s.rx_seen && s.c2.rx_enable) begin
          next_s.st.idle = 1'b1; // [R21]
          next_s.rx_seen = 1'b0;
        end
      end
      next_s.rx_sub = s.rx_sub + 4'h1;
      unique case (s.rx_state)
        async_serial_pkg::RX_WAIT_ONE: begin
          if (s.sync1) next_s.rx_state = async_serial_pkg::RX_IDLE; // [R6]
        end
        async_serial_pkg::RX_IDLE: begin
          if (!s.sync1) begin
            next_s.rx_state = async_serial_pkg::RX_START; // [R1]
            next_s.rx_sub   = 4'h1;
            next_s.rx_sh    = '0;
          end
        end
        async_serial_pkg::RX_START: begin
          if (s.rx_sub == async_serial_pkg::VER_A) next_s.rx_smp[0] = s.sync1;
          if (s.rx_sub == async_serial_pkg::VER_B) next_s.rx_smp[1] = s.sync1;
          if (s.rx_sub == async_serial_pkg::VER_C) begin
            trio = {s.sync1, s.rx_smp[1:0]};
            if (maj(trio)) begin
              next_s.rx_state = async_serial_pkg::RX_IDLE; // [R2]
            end else begin
              next_s.rx_state = async_serial_pkg::RX_BITS; // [R2]
              next_s.rx_idx   = 4'h0;
              next_s.rx_noise = (|trio) & ~(&trio); // [R4]
            end
          end
        end
        async_serial_pkg::RX_BITS: begin
          if (s.rx_sub == async_serial_pkg::SMP_A) next_s.rx_smp[0] = s.sync1;
          if (s.rx_sub == async_serial_pkg::SMP_B) next_s.rx_smp[1] = s.sync1;
          if (s.rx_sub == async_serial_pkg::SMP_C) begin
            trio            = {s.sync1, s.rx_smp[1:0]};
            vote            = maj(trio); // [R3]
            dis             = (|trio) & ~(&trio);
            next_s.rx_noise = s.rx_noise | dis; // [R4]
            if (s.rx_idx != 4'h0 && s.rx_idx <= dlast) next_s.rx_sh[s.rx_idx - 4'h1] = vote;
            if (s.rx_idx == dlast + 4'h1) rx_done = 1'b1; // [R23]
          end
          if (s.rx_sub == async_serial_pkg::SUB_LAST) next_s.rx_idx = s.rx_idx + 4'h1;
        end
      endcase
    end
    if (rx_done) begin
      msb      = s.c1.word9 ? s.rx_sh[8] : s.rx_sh[7];
      brk      = !vote && (s.rx_sh == 9'h000);
      wake_hit = s.c2.rx_sleep_ctrl && s.c1.wake_addr && msb; // [R8]
      // bad stop taken as a one: idle state re-arms start at once, except a break, which waits for a one first
      next_s.rx_state = brk ? async_serial_pkg::RX_WAIT_ONE : async_serial_pkg::RX_IDLE; // [R5] [R6]
      if (wake_hit) next_s.c2.rx_sleep_ctrl = 1'b0; // [R8]
      if (s.c2.rx_enable && (!s.c2.rx_sleep_ctrl || wake_hit)) begin // [R7]
        next_s.rx_seen = 1'b1;
        if (s.st.rx_buffer_full || s.st.frame_error_flag) begin
          next_s.st.overrun = 1'b1; // [R24] [R20]
        end else begin
          rx_fill                    = 1'b1;
          next_s.st.rx_buffer_full   = 1'b1; // [R19]
          next_s.rx_hold             = s.rx_sh[7:0];
          next_s.c1.rx_bit8          = s.rx_sh[8];
          next_s.st.noise_flag       = next_s.st.noise_flag | s.rx_noise | dis; // [R20]
          next_s.st.frame_error_flag = !vote; // [R20]
        end
      end
    end
    if (!s.c2.rx_enable) next_s.rx_state = async_serial_pkg::RX_WAIT_ONE;
    next_s.irq = (next_s.c2.tx_empty_irq_en & next_s.st.tx_buffer_empty)
               | (next_s.c2.tx_complete_irq_en & next_s.st.tx_complete) // [R17]
               | (next_s.c2.rx_irq_en & (next_s.st.rx_buffer_full | next_s.st.overrun))
               | (next_s.c2.idle_irq_en & next_s.st.idle); // [R21]
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s           <= '0;
      s.st        <= async_serial_pkg::STATUS_RST;
      s.tx_line   <= 1'b1;
      s.tx_oe_n   <= 1'b1;
      s.sclk_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o        = {24'h000000, s.rdat};
  assign wb_ack_o        = s.ack;
  assign tx_data_o       = s.tx_line;
  assign tx_data_oe_n_o  = s.tx_oe_n;
  assign sync_clk_o      = s.sclk;
  assign sync_clk_oe_n_o = s.sclk_oe_n;
  assign irq_o           = s.irq;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_status_then_read;
    stat_rd ##3 (dat_rd && !rx_done);
  endsequence
  sequence seq_armed_write;
    s.arm && dat_wr && !tx_bit;
  endsequence

  a_tx_load_empty: assert property (tx_load && !dat_wr |=> // [R15]
    s.st.tx_buffer_empty && s.tx_kind == async_serial_pkg::TX_DATA && !s.tx_line)
    else $error("load did not set empty flag or start bit");
  a_pin_release: assert property ( // [R12]
    !s.c2.tx_enable && s.tx_kind == async_serial_pkg::TX_IDLE |=> s.tx_oe_n && s.sclk_oe_n)
    else $error("pins driven while transmitter off");
  a_frame_drive: assert property ( // [R18]
    s.tx_kind != async_serial_pkg::TX_IDLE |-> !s.tx_oe_n)
    else $error("data pin released mid frame");
  a_clk_quiet: assert property ( // [R10]
    s.tx_kind != async_serial_pkg::TX_DATA || s.tx_idx == 4'h0
    |-> s.sclk == $past(s.c1.clock_polarity_sel))
    else $error("sync clock active outside data bits");
  a_rx_fill_data: assert property (rx_fill |=> // [R19]
    s.st.rx_buffer_full && s.rx_hold == $past(s.rx_sh[7:0]))
    else $error("received byte not delivered");
  a_overrun_keep: assert property ( // [R24]
    rx_done && s.st.rx_buffer_full && s.c2.rx_enable && !s.c2.rx_sleep_ctrl
    |=> s.st.overrun && $stable(s.rx_hold))
    else $error("overrun not flagged or data disturbed");
  a_noise_set: assert property (rx_fill && s.rx_noise |=> s.st.noise_flag) // [R4]
    else $error("noise flag missed");
  a_sleep_quiet: assert property ( // [R7]
    s.c2.rx_sleep_ctrl && !s.c1.wake_addr |=> !$rose(s.st.rx_buffer_full))
    else $error("sleeping receiver filled buffer");
  a_rx_clear: assert property (seq_status_then_read |=> !s.st.rx_buffer_full) // [R25]
    else $error("receive full not cleared");
  a_tx_clear: assert property (seq_armed_write |=> !s.st.tx_complete) // [R26]
    else $error("transmit complete not cleared");
endmodule

// [tb/serial_station.sv]
// remote serial station model: frame sender and frame receiver
`timescale 1ns/100ps
module serial_station (
  input  wire logic clk_i,
  input  wire logic tx_line_i,
  input  wire logic sync_clk_i,
  output logic      rx_line_o
);
  localparam int BIT_CYC = 16;
  initial rx_line_o = 1'b1; // idle mark
  // glitch flips one cycle inside the chosen bit
  task automatic send(input logic [8:0] d, input int nb, input logic stop_v, input int glitch);
    logic [10:0] fr;
    fr = {1'b0, d, 1'b0}; // start zero, lsb first
    fr[nb+1] = stop_v;
    for (int i = 0; i < nb + 2; i++) begin
      for (int c = 0; c < BIT_CYC; c++) begin
        rx_line_o <= (i == glitch && c == 9) ? ~fr[i] : fr[i];
        @(posedge clk_i);
      end
    end
    rx_line_o <= 1'b1; // mark between messages
    @(posedge clk_i);
  endtask
  // clks counts level changes of the bit clock over the frame
  task automatic recv(input int nb, output logic [8:0] d, output logic stop_v, output int clks);
    int   n;
    logic last;
    n = 0;
    d = 9'h000;
    clks = 0;
    stop_v = 1'b0;
    while (tx_line_i !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    last = sync_clk_i;
    for (int i = 0; i < (nb + 2) * BIT_CYC; i++) begin
      @(posedge clk_i);
      if (sync_clk_i !== last) clks++;
      last = sync_clk_i;
      if (i % BIT_CYC == 7 && i >= BIT_CYC && i < (nb + 1) * BIT_CYC) d[i / BIT_CYC - 1] = tx_line_i;
      if (i % BIT_CYC == 7 && i >= (nb + 1) * BIT_CYC) stop_v = tx_line_i;
    end
  endtask
endmodule

// [tb/async_serial_unit_tb.sv]
// testbench of the async serial port over wishbone and a line station
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module async_serial_unit_tb;
  localparam logic [5:0] C1 = async_serial_pkg::IDX_CTRL1;
  localparam logic [5:0] C2 = async_serial_pkg::IDX_CTRL2;
  localparam logic [5:0] ST = async_serial_pkg::IDX_STATUS;
  localparam logic [5:0] DT = async_serial_pkg::IDX_DATA;
  logic        ref_clk_i, rst_i, cyc, stb, we, ack, tx_d, tx_oe_n, sclk, sclk_oe_n, irq, rx_line;
  logic [7:0]  adr, rd;
  logic [31:0] dat, dat_o;
  logic [8:0]  got;
  logic        stop_v;
  int          clks, miscompares, checks_done;
  wire         tx_line = tx_oe_n ? 1'b1 : tx_d; // pull-up while floated
  async_serial_unit async_serial_unit_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .serial_in_pin_i(rx_line), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tx_data_o(tx_d), .tx_data_oe_n_o(tx_oe_n), .sync_clk_o(sclk),
    .sync_clk_oe_n_o(sclk_oe_n), .irq_o(irq));
  serial_station serial_station_inst (.clk_i(ref_clk_i), .tx_line_i(tx_line),
    .sync_clk_i(sclk), .rx_line_o(rx_line));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, wd};
    // wait for the slave; only the watchdog ends a hung access
    do begin
      @(posedge ref_clk_i);
    end while (ack !== 1'b1);
    if (!w) rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e, input string nm);
    wb(1'b0, idx, 8'h00);
    `CHK(nm, e, rd)
  endtask
  task automatic clear_rx;
    repeat (300) @(posedge ref_clk_i);
    wb(1'b0, ST, 8'h00);
    wb(1'b0, DT, 8'h00);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h00000000;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd_chk(ST, 8'hC0, "status");
    rd_chk(C2, 8'h00, "ctrl2");
    wb(1'b1, 6'h20, 8'hFF);
    rd_chk(6'h20, 8'h00, "unmapped");
    $display("test reset done");
    wb(1'b1, async_serial_pkg::IDX_BAUD, 8'h00);
    wb(1'b1, C1, 8'h00);
    wb(1'b1, C2, 8'h2C);
    repeat (300) @(posedge ref_clk_i);
    rd_chk(ST, 8'hC0, "status");
    `CHK("tx oe_n", 1'b0, tx_oe_n)
    `CHK("clk idle", 1'b0, sclk)
    wb(1'b1, DT, 8'hA5);
    rd_chk(ST, 8'h00, "status");
    serial_station_inst.recv(8, got, stop_v, clks);
    `CHK("tx byte", 9'h0A5, got)
    `CHK("tx stop", 1'b1, stop_v)
    `CHK("clk edges", 14, clks)
    repeat (20) @(posedge ref_clk_i);
    rd_chk(ST, 8'hC0, "status");
    $display("test transmit done");
    serial_station_inst.send(9'h03C, 8, 1'b1, -1);
    rd_chk(ST, 8'hE0, "status");
    `CHK("irq", 1'b1, irq)
    repeat (300) @(posedge ref_clk_i);
    rd_chk(ST, 8'hF0, "status");
    rd_chk(DT, 8'h3C, "rx byte");
    rd_chk(ST, 8'hC0, "status");
    $display("test receive done");
    serial_station_inst.send(9'h011, 8, 1'b1, -1);
    serial_station_inst.send(9'h022, 8, 1'b1, -1);
    rd_chk(ST, 8'hE8, "status");
    rd_chk(DT, 8'h11, "rx byte");
    clear_rx();
    serial_station_inst.send(9'h055, 8, 1'b1, 3);
    rd_chk(ST, 8'hE4, "status");
    rd_chk(DT, 8'h55, "rx byte");
    clear_rx();
    serial_station_inst.send(9'h00F, 8, 1'b0, -1);
    rd_chk(ST, 8'hE2, "status");
    rd_chk(DT, 8'h0F, "rx byte");
    serial_station_inst.send(9'h033, 8, 1'b1, -1);
    rd_chk(DT, 8'h33, "rx byte");
    clear_rx();
    serial_station_inst.send(9'h000, 8, 1'b0, -1);
    rd_chk(ST, 8'hE2, "status");
    rd_chk(DT, 8'h00, "rx byte");
    clear_rx();
    $display("test receive errors done");
    wb(1'b1, C2, 8'h24);
    repeat (200) @(posedge ref_clk_i);
    `CHK("tx oe_n", 1'b1, tx_oe_n)
    `CHK("clk oe_n", 1'b1, sclk_oe_n)
    wb(1'b1, C1, 8'h51);
    wb(1'b1, C2, 8'h2C);
    rd_chk(ST, 8'hC0, "status");
    wb(1'b1, DT, 8'h5A);
    serial_station_inst.recv(9, got, stop_v, clks);
    `CHK("tx word9", 9'h15A, got)
    `CHK("clk edges", 18, clks)
    serial_station_inst.send(9'h1C3, 9, 1'b1, -1);
    rd_chk(C1, 8'hD1, "ctrl1");
    rd_chk(DT, 8'hC3, "rx byte");
    clear_rx();
    $display("test nine bit done");
    wb(1'b1, DT, 8'h81);
    rd = 8'h00;
    for (int i = 0; i < 100 && rd[7] !== 1'b1; i++) wb(1'b0, ST, 8'h00);
    wb(1'b1, C2, 8'h24);
    serial_station_inst.recv(9, got, stop_v, clks);
    `CHK("tx word9", 9'h181, got)
    repeat (40) @(posedge ref_clk_i);
    `CHK("tx oe_n", 1'b1, tx_oe_n)
    rd_chk(ST, 8'hC0, "status");
    $display("test disable done");
    wb(1'b1, C1, 8'h00);
    wb(1'b1, C2, 8'h26);
    serial_station_inst.send(9'h012, 8, 1'b1, -1);
    rd_chk(ST, 8'hC0, "status");
    repeat (300) @(posedge ref_clk_i);
    rd_chk(C2, 8'h24, "ctrl2");
    serial_station_inst.send(9'h034, 8, 1'b1, -1);
    rd_chk(ST, 8'hE0, "status");
    clear_rx();
    wb(1'b1, C1, 8'h08);
    wb(1'b1, C2, 8'h26);
    serial_station_inst.send(9'h012, 8, 1'b1, -1);
    rd_chk(ST, 8'hC0, "status");
    serial_station_inst.send(9'h092, 8, 1'b1, -1);
    rd_chk(ST, 8'hE0, "status");
    rd_chk(C2, 8'h24, "ctrl2");
    rd_chk(DT, 8'h92, "rx byte");
    $display("test wake-up done");
    wb(1'b1, C1, 8'h06);
    wb(1'b1, C2, 8'h2C);
    `CHK("clk idle", 1'b1, sclk)
    wb(1'b1, DT, 8'h3C);
    serial_station_inst.recv(8, got, stop_v, clks);
    `CHK("tx byte", 9'h03C, got)
    `CHK("clk edges", 14, clks)
    $display("test clock phase done");
    wrap_up();
  end
endmodule
